// >>> src/accel_resp_cfg.svh
// Constants for the status and acceleration response builder
`ifndef ACCEL_RESP_CFG_SVH
`define ACCEL_RESP_CFG_SVH

// Command codes and the broadcast address
`define CMD_STATUS      4'h1
`define CMD_ACCEL       4'h2
`define ADDR_GLOBAL     4'h0

// Response lengths in bits
`define LEN_TRUNC8      5'h08
`define LEN_TRUNC9      5'h09
`define LEN_FULL        5'h0A
`define LEN_LONG        5'h10

// Acceleration codes, offset binary
`define ACCEL_ERROR     10'h000
`define ACCEL_MIN       10'h001
`define ACCEL_ZERO_G    10'h200

// Register byte offsets
`define OFS_CTRL        8'h00
`define OFS_SETUP       8'h04
`define OFS_STATUS      8'h08
`define OFS_ACCEL       8'h0C
`define OFS_COUNT       8'h10

// Control register fields and reset value
`define CTRL_ADDR_LSB   0
`define CTRL_ENH_BIT    4
`define CTRL_CLOSE_BIT  5
`define CTRL_RESET      8'h00

// Setup register fields and reset value
`define SETUP_TAG_LSB   0
`define SETUP_FUSE_LSB  2
`define SETUP_RESET     8'h00

// Status register bit positions
`define STAT_FAULT_BIT  0
`define STAT_SELF_BIT   1
`define STAT_OTP_BIT    2
`define STAT_CAP_BIT    3
`define STAT_CLOSE_BIT  4

`endif

// >>> src/accel_resp_pkg.sv
// Types shared by the response builder and its users
package accel_resp_pkg;

  // One received command frame, already checked by the framer
  typedef struct packed {
    logic       crcOk;
    logic       enhanced;
    logic       longFmt;
    logic [4:0] len;
    logic [7:0] data;
    logic [3:0] addr;
    logic [3:0] code;
  } cmd_t;

  // One response frame, right aligned in data
  typedef struct packed {
    logic        longFmt;
    logic [4:0]  len;
    logic [15:0] data;
  } resp_t;

  // Device condition flags from neighbouring logic
  typedef struct packed {
    logic fault;
    logic selfcheck;
    logic otpWrite;
  } flags_t;

  // Avalon-MM slave request
  typedef struct packed {
    logic [7:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } avs_req_t;

  // Whole state of the builder
  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [3:0]  devAddr;
    logic        enhEn;
    logic        chainClose;
    logic [1:0]  tagBits;
    logic [1:0]  fuseBits;
    logic        capMeta;
    logic        capLow;
    logic        respValid;
    resp_t       resp;
    logic [9:0]  accelSnap;
    logic [15:0] respCount;
    logic [15:0] dropCount;
  } state_t;

endpackage : accel_resp_pkg

// >>> src/accel_squeeze.sv
// Acceleration result truncation with zero substitution
`timescale 1ns/10ps
`include "accel_resp_cfg.svh"

module accel_squeeze (
  input  wire logic [9:0] raw,
  input  wire logic [4:0] len,
  output logic      [9:0] value
);

  // Drop low bits for 8 and 9 bit frames; a good reading never becomes zero
  always_comb begin
    value = raw;
    if (len == `LEN_TRUNC8) begin
      value = {2'h0, raw[9:2]};
    end else if (len == `LEN_TRUNC9) begin
      value = {1'h0, raw[9:1]};
    end
    if (raw != `ACCEL_ERROR && value == `ACCEL_ERROR) begin
      value = `ACCEL_MIN;
    end
  end

endmodule : accel_squeeze

// >>> src/accel_status_response_builder.sv
// Status and acceleration command handling with Avalon-MM registers
//
// How it works
// - Fault flag reads 1 on internal error, 0 otherwise, both responses.
// - Status carries chain switch close request, 1 closed, 0 open.
// - Self-check running bit is 1 while self-test circuitry is active.
// - Reserve capacitor low comparator sets its status bit.
// - OTP write allowed bit shows user OTP programming enable.
// - Host tag bits come from the device setup register.
// - Long status: address 15:12, zeros 11:8, flags in 7:0.
// - Short response length follows received command length, zero padded; long is 16.
// - Command code 0010 decodes as acceleration read.
// - Standard formats always; enhanced formats only once enabled.
// - Acceleration read to broadcast address 0000 gets no answer.
// - Acceleration read answered only when address matches ours.
// - Command data bits serve the CRC only, nothing else.
// - Long acceleration: address, zero, fault flag, ten result bits.
// - Short lengths 8, 9, 12 carry 8, 9, 10 bits, extras above.
// - Fewer than ten result bits drops the low bits.
// - Truncation of a good reading to zero sends 1 instead.
// - Result is offset binary, zero g at mid code, all ones max.
// - Code 1 is most negative; code 0 only reports sensor error.
// - Command code 0001 decodes as status request.
// - Short status: zeros 14:8, flags in 7:0.
`timescale 1ns/10ps
`include "accel_resp_cfg.svh"

module accel_status_response_builder (
  input  wire logic                      clock,
  input  wire logic                      rst,
  // Avalon-MM slave
  input  wire accel_resp_pkg::avs_req_t  avsReq,
  output logic                [31:0]     avsReaddata,
  output logic                           avsWaitrequest,
  // Command frames from the link framer
  input  wire logic                      cmdValid,
  input  wire accel_resp_pkg::cmd_t      cmd,
  // Device condition flags and sensor result
  input  wire accel_resp_pkg::flags_t    flags,
  input  wire logic                      capLowPin,
  input  wire logic                [9:0] accelResult,
  // Response frames to the link framer
  output logic                           respValid,
  output accel_resp_pkg::resp_t          resp,
  output logic                           chainSwitchClose
);

  import accel_resp_pkg::*;

  state_t     state_reg;
  state_t     state_next;
  logic [9:0] squeezed;
  logic       isStatus;
  logic       isAccel;
  logic       addrMatch;
  logic       formatOk;
  logic       answer;
  logic [7:0] flagByte;
  logic [14:0] shortAccel;
  logic [15:0] lenMask;
  logic       busAccess;

  // Result truncated to the length of the received frame
  // low bits dropped
  accel_squeeze squeeze (
    .raw   (accelResult),
    .len   (cmd.len),
    .value (squeezed)
  );

  // Command classification
  always_comb begin
    isStatus  = (cmd.code == `CMD_STATUS);
    isAccel   = (cmd.code == `CMD_ACCEL);
    addrMatch = (cmd.addr == state_reg.devAddr) &&
                (cmd.addr != `ADDR_GLOBAL);
    formatOk  = !cmd.enhanced || state_reg.enhEn;
    answer    = cmdValid && cmd.crcOk && addrMatch && formatOk &&
                (isStatus || isAccel);
  end

  // Shared status flag byte, lowest bit always zero
  always_comb begin
    flagByte = 8'h00;
    flagByte[7] = flags.otpWrite;
    flagByte[6] = state_reg.capLow;
    flagByte[5] = flags.selfcheck;
    flagByte[4] = state_reg.chainClose;
    flagByte[3:2] = state_reg.tagBits;
    flagByte[1] = flags.fault;
  end

  // Full short acceleration word; the length mask trims it later
  always_comb begin
    shortAccel = {state_reg.fuseBits[1], state_reg.fuseBits[0],
                  flags.selfcheck, 1'h0, flags.fault, squeezed};
  end

  // Ones in the low cmd.len bits; longer frames keep all sixteen
  always_comb begin
    if (cmd.len >= `LEN_LONG) begin
      lenMask = 16'hFFFF;
    end else begin
      lenMask = ~(16'hFFFF << cmd.len);
    end
  end

  // Avalon request present this cycle
  assign busAccess = avsReq.read || avsReq.write;

  // Next state of the whole block
  always_comb begin
    state_next = state_reg;

    // Comparator pin crosses in through two flops
    // synchronised comparator
    state_next.capMeta = capLowPin;
    state_next.capLow  = state_reg.capMeta;

    // Sensor result held for software inspection
    // offset binary kept raw
    state_next.accelSnap = accelResult;

    // Response pulse lasts one cycle
    state_next.respValid = 1'b0;

    // Build the response frame
    if (answer) begin
      state_next.respValid    = 1'b1;
      state_next.resp.longFmt = cmd.longFmt;
      state_next.resp.len     = cmd.longFmt ? `LEN_LONG : cmd.len;
      if (state_reg.respCount != 16'hFFFF) begin
        state_next.respCount = state_reg.respCount + 16'h0001;
      end
      if (isStatus) begin
        if (cmd.longFmt) begin
          state_next.resp.data = {state_reg.devAddr, 4'h0, flagByte};
        end else begin
          state_next.resp.data = {8'h00, flagByte} & lenMask;
        end
      end else begin
        if (cmd.longFmt) begin
          state_next.resp.data = {state_reg.devAddr, 1'h0,
                                  flags.fault, accelResult};
        end else begin
          state_next.resp.data = {1'h0, shortAccel} & lenMask;
        end
      end
    end else if (cmdValid && (isStatus || isAccel)) begin
      // Counted so software can see dropped commands
      if (state_reg.dropCount != 16'hFFFF) begin
        state_next.dropCount = state_reg.dropCount + 16'h0001;
      end
    end

    // Bus slave: one wait cycle, then the answer
    if (state_reg.ack) begin
      state_next.ack = 1'b0;
      if (avsReq.write && avsReq.byteenable[0]) begin
        unique case (avsReq.address)
          `OFS_CTRL: begin
            state_next.devAddr =
              avsReq.writedata[`CTRL_ADDR_LSB +: 4];
            state_next.enhEn = avsReq.writedata[`CTRL_ENH_BIT];
            state_next.chainClose =
              avsReq.writedata[`CTRL_CLOSE_BIT];
          end
          `OFS_SETUP: begin
            state_next.tagBits =
              avsReq.writedata[`SETUP_TAG_LSB +: 2];
            state_next.fuseBits =
              avsReq.writedata[`SETUP_FUSE_LSB +: 2];
          end
          `OFS_COUNT: begin
            // Any write with byte 0 enabled clears both counters
            state_next.respCount = 16'h0000;
            state_next.dropCount = 16'h0000;
          end
          default: begin
            // Read only or unmapped: ignored
          end
        endcase
      end
    end else if (busAccess) begin
      state_next.ack   = 1'b1;
      state_next.rdata = 32'h0000_0000;
      unique case (avsReq.address)
        `OFS_CTRL: begin
          state_next.rdata[`CTRL_ADDR_LSB +: 4] = state_reg.devAddr;
          state_next.rdata[`CTRL_ENH_BIT]       = state_reg.enhEn;
          state_next.rdata[`CTRL_CLOSE_BIT]     = state_reg.chainClose;
        end
        `OFS_SETUP: begin
          state_next.rdata[`SETUP_TAG_LSB +: 2]  = state_reg.tagBits;
          state_next.rdata[`SETUP_FUSE_LSB +: 2] = state_reg.fuseBits;
        end
        `OFS_STATUS: begin
          state_next.rdata[`STAT_FAULT_BIT] = flags.fault;
          state_next.rdata[`STAT_SELF_BIT]  = flags.selfcheck;
          state_next.rdata[`STAT_OTP_BIT]   = flags.otpWrite;
          state_next.rdata[`STAT_CAP_BIT]   = state_reg.capLow;
          state_next.rdata[`STAT_CLOSE_BIT] = state_reg.chainClose;
        end
        `OFS_ACCEL: begin
          state_next.rdata[9:0] = state_reg.accelSnap;
        end
        `OFS_COUNT: begin
          state_next.rdata = {state_reg.dropCount, state_reg.respCount};
        end
        default: begin
          // Unmapped reads return zero
        end
      endcase
    end
  end

  // State register; counts saturate rather than wrap so that a
  // long unattended run never shows a misleading small figure
  always_ff @(posedge clock) begin
    if (rst) begin
      state_reg            <= '0;
      state_reg.devAddr    <= 4'(`CTRL_RESET);
      state_reg.tagBits    <= 2'(`SETUP_RESET);
      state_reg.fuseBits   <= 2'(`SETUP_RESET);
      state_reg.accelSnap  <= `ACCEL_ZERO_G;
    end else begin
      state_reg <= state_next;
    end
  end

  // Outputs straight from the state, waitrequest from the state and the live request
  assign respValid        = state_reg.respValid;
  assign resp             = state_reg.resp;
  assign avsReaddata      = state_reg.rdata;
  assign avsWaitrequest   = busAccess && !state_reg.ack;
  assign chainSwitchClose = state_reg.chainClose;

endmodule : accel_status_response_builder

// >>> tb/accel_status_response_builder_tb.sv
// Self-checking bench for the response builder
`timescale 1ns/10ps
module accel_status_response_builder_tb;
  import accel_resp_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  avs_req_t avsReq = '0;
  logic [31:0] avsReaddata, rd;
  logic avsWaitrequest, cmdValid, respValid, chainSwitchClose;
  cmd_t cmd, c;
  resp_t resp;
  flags_t flags = '0;
  logic capLowPin = 1'b0;
  logic [9:0] accelResult = 10'h200;
  logic [15:0] seed = 16'h0017;
  logic [9:0] vals[6] = '{10'h000, 10'h001, 10'h003, 10'h004, 10'h200,
                          10'h3FF};
  logic [4:0] lens[4] = '{5'h08, 5'h09, 5'h0C, 5'h0F};
  int failures = 0;
  int testsRun = 0;
  int cycles = 0;

  always #12.5 clock = ~clock;

  accel_status_response_builder i_accel_status_response_builder (
    .clock(clock), .rst(rst), .avsReq(avsReq), .avsReaddata(avsReaddata),
    .avsWaitrequest(avsWaitrequest), .cmdValid(cmdValid), .cmd(cmd),
    .flags(flags), .capLowPin(capLowPin), .accelResult(accelResult),
    .respValid(respValid), .resp(resp), .chainSwitchClose(chainSwitchClose));
  cmd_master master (.clock(clock), .cmdValid(cmdValid), .cmd(cmd));

  function automatic logic [15:0] nxt(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : nxt

  // Expected frame; close is set and tag 10, fuse 01 after setup
  function automatic logic [15:0] frame(input cmd_t k);
    logic [9:0] sq;
    logic [15:0] d;
    sq = (k.len == 5'h08) ? accelResult >> 2 :
         (k.len == 5'h09) ? accelResult >> 1 : accelResult;
    if (sq == 10'h000 && accelResult != 10'h000) sq = 10'h001;
    if (k.code == 4'h1) d = {k.longFmt ? 8'h50 : 8'h00, flags.otpWrite,
      capLowPin, flags.selfcheck, 3'b110, flags.fault, 1'b0};
    else if (k.longFmt) d = {4'h5, 1'b0, flags.fault, accelResult};
    else d = {3'b001, flags.selfcheck, 1'b0, flags.fault, sq};
    return k.longFmt ? d : d & ((16'h1 << k.len) - 16'h1);
  endfunction : frame

  function automatic logic answers(input cmd_t k, input logic [3:0] me);
    return k.crcOk && k.addr == me && me != 4'h0
      && (k.code == 4'h1 || k.code == 4'h2);
  endfunction : answers

  task check(input string nm, input logic [31:0] seen, exp);
    testsRun++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  // Request held until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    avsReq <= '{a, !w, w, d, 4'hF};
    do @(posedge clock); while (avsWaitrequest !== 1'b0);
    rd = avsReaddata;
    avsReq.read <= 1'b0;
    avsReq.write <= 1'b0;
  endtask : bus

  task send(input cmd_t k, input logic [3:0] me);
    master.issue(k);
    @(negedge clock);
    check("respValid", respValid, answers(k, me));
    if (answers(k, me)) check("resp", resp.data, frame(k));
  endtask : send

  task stopTest();
    $display("checks %0d mismatches %0d", testsRun, failures);
    if (failures == 0 && testsRun > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : stopTest

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 8000) begin
      failures++;
      stopTest();
    end
  end

  initial begin
    repeat (8) @(posedge clock);
    rst <= 1'b0;
    send('{1'b1, 1'b0, 1'b1, 5'h10, 8'h00, 4'h5, 4'h1}, 4'h0);
    bus(1'b0, 8'h00, 32'h0);
    check("ctrl", rd, 32'h0);
    // Enhanced frame refused while enhanced formats are off
    bus(1'b1, 8'h00, 32'h25);
    send('{1'b1, 1'b1, 1'b1, 5'h10, 8'h00, 4'h5, 4'h1}, 4'h0);
    bus(1'b1, 8'h00, 32'h35);
    bus(1'b1, 8'h04, 32'h06);
    bus(1'b0, 8'h20, 32'h0);
    check("unmapped", rd, 32'h0);
    check("close", chainSwitchClose, 1'b1);
    @(posedge clock);
    flags <= 3'b101;
    capLowPin <= 1'b1;
    // Comparator needs two flops before its bit shows
    repeat (3) @(posedge clock);
    bus(1'b0, 8'h08, 32'h0);
    check("status", rd, 32'h1D);
    bus(1'b0, 8'h0C, 32'h0);
    check("accel", rd, 32'h200);
    $display("test registers done");
    // Truncation corners at short lengths 8, 9, 12 and 15
    foreach (vals[i]) foreach (lens[j]) begin
      @(posedge clock);
      accelResult <= vals[i];
      send('{1'b1, 1'b0, 1'b0, lens[j], 8'hA5, 4'h5, 4'h2}, 4'h5);
    end
    $display("test truncation done");
    repeat (80) begin
      seed = nxt(seed);
      @(posedge clock);
      flags <= flags_t'(seed[14:12]);
      capLowPin <= seed[15];
      accelResult <= {seed[5:0], seed[15:12]};
      repeat (3) @(posedge clock);
      c = '{seed[9] | seed[10], seed[11], seed[8], {2'b01, seed[6:4]},
        seed[7:0], seed[3] ? 4'h5 : seed[7:4], {2'b00, seed[1:0]}};
      send(c, 4'h5);
    end
    $display("test random frames done");
    stopTest();
  end
endmodule : accel_status_response_builder_tb

// >>> tb/cmd_master.sv
// Bus master model issuing command frames
`timescale 1ns/10ps
module cmd_master (
  input  wire logic           clock,
  output logic                cmdValid,
  output accel_resp_pkg::cmd_t cmd
);
  import accel_resp_pkg::*;
  // Idle until the first frame
  initial begin
    cmdValid = 1'b0;
    cmd = '0;
  end
  // code field
  // Lines show the inverse once released, so stale data never matches
  task issue(input cmd_t k);
    @(posedge clock);
    cmdValid <= 1'b1;
    cmd <= k;
    @(posedge clock);
    cmdValid <= 1'b0;
    cmd <= ~k;
  endtask : issue
endmodule : cmd_master

// >>> tb/resp_builder_props.sv
// Port checker for the response builder
`timescale 1ns/10ps
module resp_builder_props (
  input wire logic                   clock,
  input wire logic                   rst,
  input wire accel_resp_pkg::avs_req_t avsReq,
  input wire logic                   avsWaitrequest,
  input wire logic                   cmdValid,
  input wire accel_resp_pkg::cmd_t   cmd,
  input wire accel_resp_pkg::flags_t flags,
  input wire logic             [9:0] accelResult,
  input wire logic                   respValid,
  input wire accel_resp_pkg::resp_t  resp,
  input wire logic                   chainSwitchClose
);
  import accel_resp_pkg::*;
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (rst);
  crc_drop_a: assert property (cmdValid && !cmd.crcOk |=> !respValid)
    else $error("answer to a bad frame");
  bcast_drop_a: assert property (cmdValid && cmd.addr == 4'h0
    |=> !respValid) else $error("answer to broadcast");
  code_drop_a: assert property (cmdValid && cmd.code != 4'h1
    && cmd.code != 4'h2 |=> !respValid) else $error("unknown code answered");
  resp_cause_a: assert property (respValid |-> $past(cmdValid))
    else $error("response without command");
  stat_long_a: assert property (respValid && resp.longFmt
    && $past(cmd.code) == 4'h1 |-> resp.data[11:8] == 4'h0
    && resp.data[1:0] == {$past(flags.fault), 1'b0}
    && resp.data[4] == $past(chainSwitchClose)) else $error("bad status");
  acc_long_a: assert property (respValid && resp.longFmt
    && $past(cmd.code) == 4'h2 |-> resp.data[9:0] == $past(accelResult)
    && resp.data[11:10] == {1'b0, $past(flags.fault)}) else $error("bad long");
  short_len_a: assert property (respValid && !resp.longFmt
    |-> resp.len == $past(cmd.len) && (resp.data >> resp.len) == 16'h0)
    else $error("bad short length");
  min_code_a: assert property (respValid && !resp.longFmt
    && $past(cmd.code) == 4'h2 |-> (resp.data[9:0] == 10'h000)
    == ($past(accelResult) == 10'h000)) else $error("bad zero code");
  one_wait_a: assert property ($rose(avsReq.read | avsReq.write)
    |-> avsWaitrequest ##1 !avsWaitrequest) else $error("bad wait");
  cover property (respValid && resp.longFmt);
  cover property (respValid && !resp.longFmt);
  cover property (avsReq.read && !avsWaitrequest);
endmodule : resp_builder_props

bind accel_status_response_builder resp_builder_props i_props (
  .clock(clock), .rst(rst), .avsReq(avsReq),
  .avsWaitrequest(avsWaitrequest), .cmdValid(cmdValid), .cmd(cmd),
  .flags(flags), .accelResult(accelResult), .respValid(respValid),
  .resp(resp), .chainSwitchClose(chainSwitchClose));
